//--- rtl/line_timer_pkg.sv
// What this block does
// [RQ1] source code 0 holds the output line inactive, no pulses
// [RQ2] a source setting puts the exposure-active pulse on the line
// [RQ3] source code 2 puts the frame readout pulse on the line
// [RQ4] source code 5 drives the line from the software user level
// [RQ5] source code 7 routes the timer pulse; only then does it reach the line
// [RQ6] invert bit 0 passes the selected signal, 1 inverts it
// [RQ7] user level 0 makes the line low, 1 makes it high
// [RQ8] filter accepts a new level only after it held the programmed time
// [RQ9] accepted transitions take effect after the debounce time
// [RQ10] pulses shorter than the debounce time are dropped
// [RQ11] debounce time is 0 to 1,000,000 microseconds
// [RQ12] one timer, triggered only by exposure start
// [RQ13] trigger source 0 disables the timer, output stays inactive
// [RQ14] timer pulse width is 0 to 60,000,000 microseconds
// [RQ15] timer waits a programmable delay, same range, before asserting
// [RQ16] activation 0 starts on falling edge, 1 on rising edge
// [RQ17] activation 2 keeps output valid only while the source is low
// [RQ18] activation 3 keeps output valid only while the source is high
// [RQ19] level high: start on event, wait delay, then high while source high
// [RQ20] a one microsecond tick from the clock times all intervals
package line_timer_pkg;

	////////////////////////////////////////////////////////////////////////////
	// bus geometry and register offsets
	localparam int        ADR_W               = 8;
	localparam int        DAT_W               = 32;
	localparam int        SEL_W               = 4;
	localparam logic [7:0] ADR_LINE_CTRL       = 8'h00;
	localparam logic [7:0] ADR_DEBOUNCE        = 8'h04;
	localparam logic [7:0] ADR_TMR_CTRL        = 8'h08;
	localparam logic [7:0] ADR_TMR_DUR         = 8'h0c;
	localparam logic [7:0] ADR_PULSE_GEN_DELAY = 8'h10;
	localparam logic [7:0] ADR_STATUS          = 8'h14;

	////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int CTRL_SRC_LO   = 0;
	localparam int CTRL_INV_BIT  = 4;
	localparam int CTRL_USER_BIT = 8;
	localparam int TCTL_SRC_BIT  = 0;
	localparam int TCTL_ACT_LO   = 4;
	localparam int STAT_FILT_BIT = 0;
	localparam int STAT_RAW_BIT  = 1;
	localparam int STAT_TOUT_BIT = 2;
	localparam int STAT_BUSY_BIT = 3;
	localparam int STAT_LINE_BIT = 4;
	localparam int DEB_W         = 20;
	localparam int TMR_W         = 26;

	////////////////////////////////////////////////////////////////////////////
	// encodings
	localparam logic [2:0] SRC_OFF   = 3'h0;
	localparam logic [2:0] SRC_EXPO  = 3'h1;
	localparam logic [2:0] SRC_FRAME = 3'h2;
	localparam logic [2:0] SRC_USER  = 3'h5;
	localparam logic [2:0] SRC_TIMER = 3'h7;
	localparam logic [1:0] ACT_FALL  = 2'h0;
	localparam logic [1:0] ACT_RISE  = 2'h1;
	localparam logic [1:0] ACT_LOW   = 2'h2;
	localparam logic [1:0] ACT_HIGH  = 2'h3;

	typedef enum logic [2:0] {
		T_IDLE   = 3'b001,
		T_DELAY  = 3'b010,
		T_ACTIVE = 3'b100
	} tmr_state_t;

	////////////////////////////////////////////////////////////////////////////
	// limits, reset values, timing
	localparam logic [31:0]      DEB_MAX_US    = 32'h000f_4240;
	localparam logic [31:0]      TMR_MAX_US    = 32'h0393_8700;
	localparam logic [2:0]       RST_SRC       = SRC_OFF;
	localparam logic [1:0]       RST_ACT       = ACT_RISE;
	localparam logic [DEB_W-1:0] RST_DEB       = 20'h0_0000;
	localparam logic [TMR_W-1:0] RST_TMR       = 26'h000_0000;
	localparam int               CLK_PERIOD_PS = 4000;
	localparam int               US_PS         = 1000000;
	localparam int               TICK_CYC      = US_PS / CLK_PERIOD_PS;
	localparam logic [7:0]       TICK_LAST     = 8'(TICK_CYC - 1);

endpackage

//--- rtl/camera_io_line_timer.sv
`timescale 1ns/1ps
module camera_io_line_timer (
	// clock and reset
	input  wire logic                              core_clk_i,
	input  wire logic                              sys_rst_i,
	// wishbone classic slave
	input  wire logic                              wb_cyc_i,
	input  wire logic                              wb_stb_i,
	input  wire logic                              wb_we_i,
	input  wire logic [line_timer_pkg::ADR_W-1:0]  wb_adr_i,
	input  wire logic [line_timer_pkg::DAT_W-1:0]  wb_dat_i,
	input  wire logic [line_timer_pkg::SEL_W-1:0]  wb_sel_i,
	output logic      [line_timer_pkg::DAT_W-1:0]  wb_dat_o,
	output logic                                   wb_ack_o,
	// camera core signals, same clock
	input  wire logic                              exposure_active_i,
	input  wire logic                              readout_active_i,
	// control receptacle
	input  wire logic                              line_in_i,
	output logic                                   line_out_o,
	output logic                                   line_in_filt_o
);
	import line_timer_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// state
	typedef struct packed {
		logic                ack;
		logic [DAT_W-1:0]    rdat;
		logic [2:0]          src;
		logic                inv;
		logic                user;
		logic [DEB_W-1:0]    deb_time;
		logic                tsrc;
		logic [1:0]          tact;
		logic [TMR_W-1:0]    tdur;
		logic [TMR_W-1:0]    pulse_gen_delay;
		logic                in_meta;
		logic                in_sync;
		logic                filt;
		logic [7:0]          deb_pre;
		logic [DEB_W-1:0]    deb_us;
		tmr_state_t          tst;
		logic [7:0]          tmr_pre;
		logic [TMR_W-1:0]    tmr_us;
		logic                expo_d;
		logic                tmr_out;
		logic                line_out;
	} st_t;

	localparam st_t ST_RST = '{
		ack: 1'b0, rdat: 32'h0000_0000, src: RST_SRC, inv: 1'b0, user: 1'b0,
		deb_time: RST_DEB, tsrc: 1'b0, tact: RST_ACT, tdur: RST_TMR,
		pulse_gen_delay: RST_TMR, in_meta: 1'b0, in_sync: 1'b0, filt: 1'b0,
		deb_pre: 8'h00, deb_us: RST_DEB, tst: T_IDLE, tmr_pre: 8'h00,
		tmr_us: RST_TMR, expo_d: 1'b0, tmr_out: 1'b0, line_out: 1'b0
	};

	st_t              st_ff;
	st_t              nxt_st;
	logic [DAT_W-1:0] ctrl_word;
	logic [DAT_W-1:0] tctl_word;
	logic [DAT_W-1:0] stat_word;
	logic [DAT_W-1:0] wr_word;
	logic [DAT_W-1:0] lim_word;
	logic             req;
	logic             sel_raw;
	logic             src_ok;
	logic             expo_rise;
	logic             expo_fall;
	logic             tmr_start;
	logic             edge_mode;
	logic             level_ok;

	////////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [DAT_W-1:0] merge_lanes(input logic [DAT_W-1:0] old,
		input logic [DAT_W-1:0] dat, input logic [SEL_W-1:0] sel);
		logic [DAT_W-1:0] res;
		res = old;
		for (int i = 0; i < SEL_W; i++) begin
			if (sel[i]) begin
				res[8*i +: 8] = dat[8*i +: 8];
			end
		end
		return res;
	endfunction

	// out-of-range times saturate rather than wrap, so a large write stays large
	function automatic logic [DAT_W-1:0] clamp_us(input logic [DAT_W-1:0] v,
		input logic [DAT_W-1:0] lim);
		return (v > lim) ? lim : v;
	endfunction

	function automatic logic tick_done(input logic [7:0] pre);
		return pre == TICK_LAST;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// readback words
	always_comb begin
		ctrl_word = '0;
		ctrl_word[CTRL_SRC_LO +: 3] = st_ff.src;
		ctrl_word[CTRL_INV_BIT] = st_ff.inv;
		ctrl_word[CTRL_USER_BIT] = st_ff.user;
		tctl_word = '0;
		tctl_word[TCTL_SRC_BIT] = st_ff.tsrc;
		tctl_word[TCTL_ACT_LO +: 2] = st_ff.tact;
		stat_word = '0;
		stat_word[STAT_FILT_BIT] = st_ff.filt;
		stat_word[STAT_RAW_BIT] = st_ff.in_sync;
		stat_word[STAT_TOUT_BIT] = st_ff.tmr_out;
		stat_word[STAT_BUSY_BIT] = st_ff.tst != T_IDLE;
		stat_word[STAT_LINE_BIT] = st_ff.line_out;
	end

	////////////////////////////////////////////////////////////////////////////
	// combinational helpers for line mux and timer trigger
	always_comb begin
		src_ok = 1'b1;
		unique case (st_ff.src)
			SRC_EXPO:  sel_raw = exposure_active_i;   // [RQ2]
			SRC_FRAME: sel_raw = readout_active_i;    // [RQ3]
			SRC_USER:  sel_raw = st_ff.user;          // [RQ4]
			SRC_TIMER: sel_raw = st_ff.tmr_out;       // [RQ5]
			default: begin
				sel_raw = 1'b0;
				src_ok = 1'b0;
			end
		endcase
	end

	assign req       = wb_cyc_i & wb_stb_i & ~st_ff.ack;
	assign expo_rise = exposure_active_i & ~st_ff.expo_d;
	assign expo_fall = ~exposure_active_i & st_ff.expo_d;
	assign edge_mode = (st_ff.tact == ACT_FALL) || (st_ff.tact == ACT_RISE);
	// exposure start is the only trigger the timer knows
	assign tmr_start = st_ff.tsrc &&                                          // [RQ12]
		(((st_ff.tact == ACT_FALL) || (st_ff.tact == ACT_LOW)) ? expo_fall : expo_rise); // [RQ16]
	assign level_ok  = (st_ff.tact == ACT_HIGH) ? exposure_active_i :         // [RQ18]
		(st_ff.tact == ACT_LOW) ? ~exposure_active_i : 1'b1;                  // [RQ17]

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		nxt_st = st_ff;
		wr_word = '0;
		lim_word = '0;

		// bus: one wait-free answer, ack stands one cycle
		nxt_st.ack = req;
		nxt_st.rdat = '0;
		if (req) begin
			case (wb_adr_i)
				ADR_LINE_CTRL: begin
					nxt_st.rdat = ctrl_word;
					if (wb_we_i) begin
						wr_word = merge_lanes(ctrl_word, wb_dat_i, wb_sel_i);
						nxt_st.src = wr_word[CTRL_SRC_LO +: 3];
						nxt_st.inv = wr_word[CTRL_INV_BIT];
						nxt_st.user = wr_word[CTRL_USER_BIT];              // [RQ7]
					end
				end
				ADR_DEBOUNCE: begin
					nxt_st.rdat = 32'(st_ff.deb_time);
					if (wb_we_i) begin
						wr_word = merge_lanes(32'(st_ff.deb_time), wb_dat_i, wb_sel_i);
						lim_word = clamp_us(wr_word, DEB_MAX_US);          // [RQ11]
						nxt_st.deb_time = lim_word[DEB_W-1:0];
					end
				end
				ADR_TMR_CTRL: begin
					nxt_st.rdat = tctl_word;
					if (wb_we_i) begin
						wr_word = merge_lanes(tctl_word, wb_dat_i, wb_sel_i);
						nxt_st.tsrc = wr_word[TCTL_SRC_BIT];
						nxt_st.tact = wr_word[TCTL_ACT_LO +: 2];
					end
				end
				ADR_TMR_DUR: begin
					nxt_st.rdat = 32'(st_ff.tdur);
					if (wb_we_i) begin
						wr_word = merge_lanes(32'(st_ff.tdur), wb_dat_i, wb_sel_i);
						lim_word = clamp_us(wr_word, TMR_MAX_US);          // [RQ14]
						nxt_st.tdur = lim_word[TMR_W-1:0];
					end
				end
				ADR_PULSE_GEN_DELAY: begin
					nxt_st.rdat = 32'(st_ff.pulse_gen_delay);
					if (wb_we_i) begin
						wr_word = merge_lanes(32'(st_ff.pulse_gen_delay), wb_dat_i, wb_sel_i);
						lim_word = clamp_us(wr_word, TMR_MAX_US);          // [RQ15]
						nxt_st.pulse_gen_delay = lim_word[TMR_W-1:0];
					end
				end
				ADR_STATUS: begin
					nxt_st.rdat = stat_word;
				end
				default: begin
					nxt_st.rdat = '0;
				end
			endcase
		end

		// input pin: two-stage synchroniser
		nxt_st.in_meta = line_in_i;
		nxt_st.in_sync = st_ff.in_meta;

		// debounce: a mismatch must survive deb_time whole microseconds
		if (st_ff.in_sync == st_ff.filt) begin
			nxt_st.deb_pre = 8'h00;                                        // [RQ10]
			nxt_st.deb_us = '0;
		end else if (st_ff.deb_us == st_ff.deb_time) begin
			nxt_st.filt = st_ff.in_sync;                                   // [RQ8]
			nxt_st.deb_pre = 8'h00;
			nxt_st.deb_us = '0;
		end else if (tick_done(st_ff.deb_pre)) begin
			nxt_st.deb_pre = 8'h00;                                        // [RQ20]
			nxt_st.deb_us = st_ff.deb_us + 20'h0_0001;                     // [RQ9]
		end else begin
			nxt_st.deb_pre = st_ff.deb_pre + 8'h01;
		end

		// timer
		nxt_st.expo_d = exposure_active_i;
		if (tick_done(st_ff.tmr_pre)) begin
			nxt_st.tmr_pre = 8'h00;                                        // [RQ20]
			nxt_st.tmr_us = st_ff.tmr_us + 26'h000_0001;
		end else begin
			nxt_st.tmr_pre = st_ff.tmr_pre + 8'h01;
		end
		unique case (st_ff.tst)
			T_IDLE: begin
				nxt_st.tmr_pre = 8'h00;
				nxt_st.tmr_us = '0;
				if (tmr_start) begin
					if (st_ff.pulse_gen_delay != '0) begin
						nxt_st.tst = T_DELAY;                              // [RQ15]
					end else if (edge_mode && st_ff.tdur == '0) begin
						nxt_st.tst = T_IDLE;
					end else begin
						nxt_st.tst = T_ACTIVE;
					end
				end
			end
			T_DELAY: begin
				// a level mode whose level is gone has nothing left to show
				if (!level_ok) begin
					nxt_st.tst = T_IDLE;                                   // [RQ19]
				end else if (st_ff.tmr_us == st_ff.pulse_gen_delay) begin
					nxt_st.tmr_pre = 8'h00;
					nxt_st.tmr_us = '0;
					nxt_st.tst = (edge_mode && st_ff.tdur == '0) ? T_IDLE : T_ACTIVE;
				end
			end
			T_ACTIVE: begin
				// level modes ignore the duration and follow the source
				if (edge_mode ? (st_ff.tmr_us == st_ff.tdur) : !level_ok) begin
					nxt_st.tst = T_IDLE;                                   // [RQ14]
				end
			end
		endcase
		if (!st_ff.tsrc) begin
			nxt_st.tst = T_IDLE;                                           // [RQ13]
		end
		nxt_st.tmr_out = (nxt_st.tst == T_ACTIVE) && (edge_mode || level_ok); // [RQ19]

		// output line: off stays low whatever the inverter says
		nxt_st.line_out = src_ok ? (sel_raw ^ st_ff.inv) : 1'b0;           // [RQ1] [RQ6]
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			st_ff <= ST_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign wb_ack_o       = st_ff.ack;
	assign wb_dat_o       = st_ff.rdat;
	assign line_out_o     = st_ff.line_out;
	assign line_in_filt_o = st_ff.filt;

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	property p_off;
		(st_ff.src == SRC_OFF) |=> !line_out_o;
	endproperty
	a_off: assert property (p_off) else $error("line not idle with source off"); // [RQ1]

	property p_expo;
		(st_ff.src == SRC_EXPO) |=> (line_out_o == $past(exposure_active_i ^ st_ff.inv));
	endproperty
	a_expo: assert property (p_expo) else $error("line not following exposure"); // [RQ2]

	property p_frame;
		(st_ff.src == SRC_FRAME) |=> (line_out_o == $past(readout_active_i ^ st_ff.inv));
	endproperty
	a_frame: assert property (p_frame) else $error("line not following readout"); // [RQ3]

	property p_user;
		(st_ff.src == SRC_USER && !st_ff.inv) |=> (line_out_o == $past(st_ff.user));
	endproperty
	a_user: assert property (p_user) else $error("line not at user level"); // [RQ7]

	property p_timer_route;
		(st_ff.src == SRC_TIMER) |=> (line_out_o == $past(st_ff.tmr_out ^ st_ff.inv));
	endproperty
	a_timer_route: assert property (p_timer_route) else $error("timer not routed"); // [RQ5]

	property p_invert;
		(src_ok && st_ff.inv) |=> (line_out_o == !$past(sel_raw));
	endproperty
	a_invert: assert property (p_invert) else $error("inverter not applied"); // [RQ6]

	property p_deb_wait;
		$changed(line_in_filt_o) |-> ($past(st_ff.deb_us) == $past(st_ff.deb_time));
	endproperty
	a_deb_wait: assert property (p_deb_wait) else $error("filter changed early"); // [RQ8]

	property p_deb_drop;
		(st_ff.in_sync == st_ff.filt) |=> $stable(line_in_filt_o);
	endproperty
	a_deb_drop: assert property (p_deb_drop) else $error("short pulse passed"); // [RQ10]

	property p_limits;
		(st_ff.deb_time <= DEB_MAX_US[DEB_W-1:0]) && (st_ff.tdur <= TMR_MAX_US[TMR_W-1:0]);
	endproperty
	a_limits: assert property (p_limits) else $error("time setting out of range"); // [RQ11]

	property p_disabled;
		!st_ff.tsrc |=> !st_ff.tmr_out;
	endproperty
	a_disabled: assert property (p_disabled) else $error("timer active while disabled"); // [RQ13]

	property p_no_stray_start;
		(st_ff.tst == T_IDLE && !tmr_start) |=> (st_ff.tst == T_IDLE);
	endproperty
	a_no_stray_start: assert property (p_no_stray_start) else $error("timer left idle"); // [RQ12]

	sequence s_rise_start;
		st_ff.tsrc && st_ff.tact == ACT_RISE && st_ff.tst == T_IDLE && expo_rise;
	endsequence
	property p_rise_start;
		s_rise_start |=> (st_ff.tst != T_IDLE) || (st_ff.tdur == '0 && st_ff.pulse_gen_delay == '0);
	endproperty
	a_rise_start: assert property (p_rise_start) else $error("rising edge missed"); // [RQ16]

	property p_delay_quiet;
		(st_ff.tst == T_DELAY && st_ff.tmr_us != st_ff.pulse_gen_delay) |=> !st_ff.tmr_out;
	endproperty
	a_delay_quiet: assert property (p_delay_quiet) else $error("output during delay"); // [RQ15]

	property p_dur_end;
		(st_ff.tst == T_ACTIVE && edge_mode && st_ff.tmr_us == st_ff.tdur && st_ff.tsrc)
			|=> !st_ff.tmr_out ##1 (st_ff.tst != T_ACTIVE || st_ff.tmr_us == '0);
	endproperty
	a_dur_end: assert property (p_dur_end) else $error("pulse overran duration"); // [RQ14]

	property p_lvl_high;
		(st_ff.tmr_out && st_ff.tact == ACT_HIGH && $past(st_ff.tact) == ACT_HIGH)
			|-> $past(exposure_active_i);
	endproperty
	a_lvl_high: assert property (p_lvl_high) else $error("high level not held"); // [RQ18]

	property p_lvl_low;
		(st_ff.tmr_out && st_ff.tact == ACT_LOW && $past(st_ff.tact) == ACT_LOW)
			|-> !$past(exposure_active_i);
	endproperty
	a_lvl_low: assert property (p_lvl_low) else $error("low level not held"); // [RQ17]

	property p_tick;
		(st_ff.tmr_pre <= TICK_LAST) && (st_ff.deb_pre <= TICK_LAST);
	endproperty
	a_tick: assert property (p_tick) else $error("tick prescaler overran"); // [RQ20]

	property p_ack_once;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

endmodule

//--- dv/ext_equipment.sv
`timescale 1ns/1ps
module ext_equipment (
	// pacing clock, the equipment has none of its own on this pin
	input  wire logic core_clk_i,
	// control receptacle input pin of the camera
	output logic      line_o
);

	////////////////////////////////////////////////////////////////////////////
	// a push-pull driver: the pin always shows a definite level, low at power-up
	initial line_o = 1'b0;

	task automatic drive(input logic lvl);
		@(posedge core_clk_i);
		line_o <= lvl;
	endtask

	// a glitch of n cycles, then back to the opposite level
	task automatic pulse(input logic lvl, input int n);
		drive(lvl);
		repeat (n) @(posedge core_clk_i);
		line_o <= !lvl;
	endtask

endmodule

//--- dv/tb.sv
`timescale 1ns/1ps
module tb;
	import line_timer_pkg::*;

	logic        core_clk;
	logic        sys_rst;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [7:0]  adr;
	logic [31:0] wdat;
	logic [3:0]  sel;
	logic [31:0] rdat;
	logic        ack;
	logic        expo;
	logic        rdo;
	logic        line_in;
	logic        line_out;
	logic        line_filt;
	int          n_errors;
	int          total_checks;
	logic        pol;
	logic        base;
	logic [2:0]  codes [5];

	camera_io_line_timer dut_u (
		.core_clk_i        (core_clk),
		.sys_rst_i         (sys_rst),
		.wb_cyc_i          (cyc),
		.wb_stb_i          (stb),
		.wb_we_i           (we),
		.wb_adr_i          (adr),
		.wb_dat_i          (wdat),
		.wb_sel_i          (sel),
		.wb_dat_o          (rdat),
		.wb_ack_o          (ack),
		.exposure_active_i (expo),
		.readout_active_i  (rdo),
		.line_in_i         (line_in),
		.line_out_o        (line_out),
		.line_in_filt_o    (line_filt)
	);

	ext_equipment ext_u (
		.core_clk_i (core_clk),
		.line_o     (line_in)
	);

	////////////////////////////////////////////////////////////////////////////
	initial core_clk = 1'b0;
	always #2 core_clk = !core_clk;

	task automatic give_verdict();
		if (n_errors == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// classic single cycle; a dead slave is caught by the watchdog, not here
	task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] s, output logic [31:0] q);
		@(posedge core_clk);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		sel  <= s;
		do begin
			@(posedge core_clk);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask

	task automatic wb_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] q;
		wb_xfer(1'b1, a, d, s, q);
	endtask

	task automatic wb_rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb_xfer(1'b0, a, 32'h0, 4'hf, q);
		chk(q, exp);
	endtask

	task automatic at_line(input int n, input logic e);
		repeat (n) @(posedge core_clk);
		chk({31'h0, line_out}, {31'h0, e});
	endtask

	task automatic at_filt(input int n, input logic e);
		repeat (n) @(posedge core_clk);
		chk({31'h0, line_filt}, {31'h0, e});
	endtask

	////////////////////////////////////////////////////////////////////////////
	// the longest path below is a few thousand cycles; this leaves ample room
	initial begin
		repeat (60000) @(posedge core_clk);
		n_errors++;
		give_verdict();
	end

	initial begin
		n_errors     = 0;
		total_checks = 0;
		sys_rst = 1'b1;
		cyc     = 1'b0;
		stb     = 1'b0;
		we      = 1'b0;
		adr     = 8'h00;
		wdat    = 32'h0;
		sel     = 4'h0;
		expo    = 1'b0;
		rdo     = 1'b0;
		codes   = '{SRC_OFF, SRC_EXPO, SRC_FRAME, SRC_USER, SRC_TIMER};
		repeat (16) @(posedge core_clk);
		sys_rst <= 1'b0;
		wb_rd(ADR_LINE_CTRL, 32'h0);
		wb_rd(ADR_TMR_CTRL, 32'h10);
		wb_rd(ADR_DEBOUNCE, 32'h0);
		wb_rd(8'h20, 32'h0);
		at_line(1, 1'b0);
		// source table, once with exposure and user level high, once with readout high
		for (int p = 0; p < 2; p++) begin
			expo <= (p == 0);
			rdo  <= (p == 1);
			for (int i = 0; i < 5; i++) begin
				for (int v = 0; v < 2; v++) begin
					wb_wr(ADR_LINE_CTRL, 32'(codes[i]) | (32'(v) << CTRL_INV_BIT)
						| (32'(p == 0) << CTRL_USER_BIT), 4'hf);
					base = (i == 1 || i == 3) ? (p == 0) : (i == 2) ? (p == 1) : 1'b0;
					at_line(3, (i == 0) ? 1'b0 : (base ^ v[0]));
				end
			end
		end
		// byte lanes: only the low byte lands, user level stays 0
		wb_wr(ADR_LINE_CTRL, 32'h0, 4'hf);
		wb_wr(ADR_LINE_CTRL, 32'h0000_0115, 4'h1);
		wb_rd(ADR_LINE_CTRL, 32'h15);
		at_line(2, 1'b1);
		wb_wr(ADR_DEBOUNCE, 32'h000f_ffff, 4'hf);
		wb_rd(ADR_DEBOUNCE, DEB_MAX_US);
		wb_wr(ADR_TMR_DUR, 32'h03ff_ffff, 4'hf);
		wb_rd(ADR_TMR_DUR, TMR_MAX_US);
		wb_wr(ADR_PULSE_GEN_DELAY, 32'h03ff_ffff, 4'hf);
		wb_rd(ADR_PULSE_GEN_DELAY, TMR_MAX_US);
		// debounce of 1 us is 250 cycles
		wb_wr(ADR_DEBOUNCE, 32'h1, 4'hf);
		at_filt(300, 1'b0);
		ext_u.pulse(1'b1, 100);
		at_filt(160, 1'b0);
		ext_u.drive(1'b1);
		at_filt(245, 1'b0);
		at_filt(20, 1'b1);
		// filtered and raw input high, line high from inverted user level
		wb_rd(ADR_STATUS, 32'h13);
		ext_u.pulse(1'b0, 100);
		at_filt(200, 1'b1);
		ext_u.drive(1'b0);
		at_filt(245, 1'b1);
		at_filt(20, 1'b0);
		// timer: delay 1 us, width 2 us, on the line through source 7
		wb_wr(ADR_LINE_CTRL, 32'(SRC_TIMER), 4'hf);
		wb_wr(ADR_TMR_DUR, 32'h2, 4'hf);
		wb_wr(ADR_PULSE_GEN_DELAY, 32'h1, 4'hf);
		wb_rd(ADR_PULSE_GEN_DELAY, 32'h1);
		rdo <= 1'b0;
		for (int a = 0; a < 4; a++) begin
			pol = (a == 1 || a == 3);
			wb_wr(ADR_TMR_CTRL, 32'h0, 4'hf);
			expo <= !pol;
			repeat (5) @(posedge core_clk);
			wb_wr(ADR_TMR_CTRL, (32'(a) << TCTL_ACT_LO) | 32'h1, 4'hf);
			expo <= pol;
			at_line(240, 1'b0);
			at_line(25, 1'b1);
			if (a < 2) begin
				at_line(475, 1'b1);
				at_line(30, 1'b0);
			end else begin
				at_line(335, 1'b1);
				// timer out, timer busy and line high; input low
				wb_rd(ADR_STATUS, 32'h1c);
				expo <= !pol;
				at_line(15, 1'b0);
			end
		end
		// trigger source off: exposure start must not fire the timer
		wb_wr(ADR_TMR_CTRL, 32'h10, 4'hf);
		expo <= 1'b0;
		repeat (5) @(posedge core_clk);
		expo <= 1'b1;
		at_line(265, 1'b0);
		at_line(300, 1'b0);
		give_verdict();
	end

endmodule
